// [palette_port_pkg.sv]
// Shared constants for the palette host port: widths, phases, reset values,
// host pin timing and the controller's own register map.
// Assumes both ends run on one clock; host pins are crossed by two flip-flops.
package palette_port_pkg;

  // Data and storage widths
  localparam int          BYTE_W      = 8;
  localparam int          ENTRY_W     = 24;
  localparam int          PAL_DEPTH   = 256;
  localparam int          PHASE_W     = 2;

  // Color phase codes of the modulo-three counter
  localparam logic [1:0]  PHASE_RED   = 2'h0;
  localparam logic [1:0]  PHASE_GREEN = 2'h1;
  localparam logic [1:0]  PHASE_BLUE  = 2'h2;

  // Values after reset and fixed levels
  localparam logic [7:0]  INDEX_RST   = 8'h00;
  localparam logic [7:0]  INDEX_LAST  = 8'hFF;
  localparam logic [7:0]  BLACK_LEVEL = 8'h00;
  localparam logic [7:0]  BUS_IDLE    = 8'hFF;
  localparam logic [23:0] ENTRY_RST   = 24'h000000;
  localparam logic [1:0]  OVL_RESERVED = 2'h0;

  // Host pin timing, in clk_i cycles (5 ns each)
  localparam int          CNT_W       = 4;
  localparam logic [3:0]  SETUP_CYC   = 4'h2;
  localparam logic [3:0]  STROBE_CYC  = 4'h8;
  localparam logic [3:0]  HOLD_CYC    = 4'h3;
  localparam logic [3:0]  GAP_CYC     = 4'h4;

  // Controller register map on Avalon-MM (byte addresses)
  localparam int          AV_ADDR_W   = 4;
  localparam int          AV_DATA_W   = 32;
  localparam logic [3:0]  OFS_CMD     = 4'h0;
  localparam logic [3:0]  OFS_RESULT  = 4'h4;
  localparam int          CMD_TLO_BIT = 8;
  localparam int          CMD_THI_BIT = 9;
  localparam int          CMD_READ_BIT = 10;

  // Host controller sequencer states
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_ACK    = 3'b001,
    ST_SETUP  = 3'b010,
    ST_STROBE = 3'b011,
    ST_HOLD   = 3'b100,
    ST_GAP    = 3'b101
  } host_state_t;

endpackage

// [palette_host_if.sv]
// Pin-level carrier between the palette device and its host controller.
// Assumes the testbench instantiates it once and joins both ends to it.
`timescale 1ns/1ps
interface palette_host_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic       target_sel_low;
  logic       target_sel_high;
  logic [7:0] host_dq_out;
  logic       host_dq_oe;
  logic [7:0] dev_dq_out;
  logic       dev_dq_oe;
  logic [7:0] host_data_bus;

  // Resolved level of the shared data bus, pulled high when undriven
  assign host_data_bus = dev_dq_oe  ? dev_dq_out :
                         host_dq_oe ? host_dq_out : 8'hFF;

  modport dev (
    input  cs_n, rd_n, wr_n, target_sel_low, target_sel_high, host_data_bus,
    output dev_dq_out, dev_dq_oe
  );

  modport host (
    output cs_n, rd_n, wr_n, target_sel_low, target_sel_high, host_dq_out, host_dq_oe,
    input  host_data_bus
  );
endinterface

// [palette_device_end.sv]
// Palette device end: index pointer, color phase counter, palette and
// overlay storage, host pin decode and the pixel lookup path.
// Assumes host pins arrive unrelated to clk_i; pixel inputs share clk_i.
// Functional notes
// RULE1: host access only while select low
// RULE2: pixel inputs ignored during select low
// RULE3: command pins pick index, palette, overlay
// RULE4: eight-bit index loaded by host write
// RULE5: red, green, blue bytes stored on blue
// RULE6: index advances after blue write
// RULE7: three reads, index advances after blue
// RULE8: color outputs black while select low
// RULE9: palette index wraps from last to zero
// RULE10: overlay uses low two index bits
// RULE11: storage transfers happen between host accesses
// RULE12: host updates contents during blanking
// RULE13: phase counts red, green, blue modulo three
// RULE14: phase cleared by index write only
// RULE15: index read changes nothing
// RULE16: write data taken at strobe end
// RULE17: host never drops all three strobes
// RULE18: read sequence fetches entry at start
`timescale 1ns/1ps
module palette_device_end (
  input  wire logic                                clk_i,
  input  wire logic                                sys_rst_i,
  input  wire logic                                ce_i,
  palette_host_if.dev                              bus,
  input  wire logic [palette_port_pkg::BYTE_W-1:0] pixel_index_in_i,
  input  wire logic                                overlay_pick_lo_i,
  input  wire logic                                overlay_pick_hi_i,
  output logic      [palette_port_pkg::BYTE_W-1:0] red_o,
  output logic      [palette_port_pkg::BYTE_W-1:0] green_o,
  output logic      [palette_port_pkg::BYTE_W-1:0] blue_o
);
  import palette_port_pkg::*;

  logic [12:0]          sync1, sync2;
  logic                 cs_n_s, rd_n_s, wr_n_s, tlo_s, thi_s;
  logic [7:0]           data_s;
  logic                 wr_act, rd_act, wr_end, rd_start, rd_end;

  logic [7:0]           palette_index_pointer, next_palette_index_pointer;
  logic [1:0]           phase, next_phase;
  logic [7:0]           red_hold, next_red_hold;
  logic [7:0]           green_hold, next_green_hold;
  logic [23:0]          rd_entry, next_rd_entry;
  logic                 rd_tlo, next_rd_tlo;
  logic                 rd_thi, next_rd_thi;
  logic                 wr_act_q, rd_act_q;
  logic [7:0]           dq_out, next_dq_out;
  logic                 dq_oe, next_dq_oe;
  logic                 pal_we, ovl_we;
  logic [7:0]           mem_addr;
  logic [23:0]          mem_wdata;
  logic [23:0]          palette_mem [0:PAL_DEPTH-1];
  logic [23:0]          overlay_mem [1:3];
  logic [7:0]           next_red, next_green, next_blue;
  logic [1:0]           pick;
  logic [23:0]          pix_entry;

  // Storage lookup shared by the host read path and the pixel path
  function automatic logic [23:0] fetch_entry(input logic ovl, input logic [7:0] idx);
    logic [23:0] val;
    val = ENTRY_RST;
    if (!ovl) begin
      val = palette_mem[idx];
    end else if (idx[1:0] != OVL_RESERVED) begin
      val = overlay_mem[idx[1:0]];
    end
    return val;
  endfunction

  // Next pointer value after a blue byte
  function automatic logic [7:0] advance(input logic [7:0] idx);
    logic [7:0] nxt;
    nxt = idx + 8'h01;
    if (idx == INDEX_LAST) begin
      nxt = INDEX_RST;
    end
    return nxt;
  endfunction

  // RULE11: two-stage pin crossing
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync1 <= {3'b111, 2'b00, BUS_IDLE};
      sync2 <= {3'b111, 2'b00, BUS_IDLE};
    end else if (ce_i) begin
      sync1 <= {bus.cs_n, bus.rd_n, bus.wr_n, bus.target_sel_low,
                bus.target_sel_high, bus.host_data_bus};
      sync2 <= sync1;
    end
  end

  // Decoded pin state, all taken from the second stage
  assign cs_n_s   = sync2[12];
  assign rd_n_s   = sync2[11];
  assign wr_n_s   = sync2[10];
  assign tlo_s    = sync2[9];
  assign thi_s    = sync2[8];
  assign data_s   = sync2[7:0];
  // RULE1: strobes count only with select low
  // RULE17: all three low is not decoded
  assign wr_act   = !cs_n_s && !wr_n_s && rd_n_s;
  assign rd_act   = !cs_n_s && !rd_n_s && wr_n_s;
  // RULE16: end of write on first rising edge
  assign wr_end   = wr_act_q && !wr_act;
  assign rd_start = rd_act && !rd_act_q;
  assign rd_end   = rd_act_q && !rd_act;

  // Host access sequencing
  always_comb begin
    next_palette_index_pointer = palette_index_pointer;
    next_phase                 = phase;
    next_red_hold              = red_hold;
    next_green_hold            = green_hold;
    next_rd_entry              = rd_entry;
    next_rd_tlo                = rd_tlo;
    next_rd_thi                = rd_thi;
    next_dq_out                = dq_out;
    next_dq_oe                 = dq_oe;
    pal_we                     = 1'b0;
    ovl_we                     = 1'b0;
    mem_addr                   = palette_index_pointer;
    mem_wdata                  = {red_hold, green_hold, data_s};
    if (wr_end) begin
      // RULE3: low command pin selects index
      if (!tlo_s) begin
        // RULE4: load index from bus
        next_palette_index_pointer = data_s;
        // RULE14: phase cleared on index write
        next_phase                 = PHASE_RED;
      end else begin
        // RULE13: phase steps red, green, blue
        unique case (phase)
          PHASE_RED: begin
            next_red_hold = data_s;
            next_phase    = PHASE_GREEN;
          end
          PHASE_GREEN: begin
            next_green_hold = data_s;
            next_phase      = PHASE_BLUE;
          end
          PHASE_BLUE: begin
            // RULE5: combine bytes on blue
            // RULE10: reserved overlay slot dropped
            pal_we = !thi_s;
            ovl_we = thi_s && (palette_index_pointer[1:0] != OVL_RESERVED);
            // RULE6: step index after blue write
            // RULE9: last entry wraps to zero
            next_palette_index_pointer = advance(palette_index_pointer);
            next_phase                 = PHASE_RED;
          end
          default: begin
            next_phase = PHASE_RED;
          end
        endcase
      end
    end
    if (rd_start) begin
      next_rd_tlo = tlo_s;
      next_rd_thi = thi_s;
      next_dq_oe  = 1'b1;
      if (!tlo_s) begin
        // RULE15: index read has no side effect
        next_dq_out = palette_index_pointer;
      end else if (phase == PHASE_RED) begin
        // RULE18: whole entry fetched at red
        next_rd_entry = fetch_entry(thi_s, palette_index_pointer);
        next_dq_out   = next_rd_entry[23:16];
      end else if (phase == PHASE_GREEN) begin
        next_dq_out = rd_entry[15:8];
      end else begin
        next_dq_out = rd_entry[7:0];
      end
    end
    if (rd_end) begin
      next_dq_oe = 1'b0;
      if (rd_tlo) begin
        // RULE7: step index after blue read
        if (phase == PHASE_BLUE) begin
          next_palette_index_pointer = advance(palette_index_pointer);
          next_phase                 = PHASE_RED;
        end else begin
          next_phase = phase + 2'h1;
        end
      end
    end
  end

  // Host side state registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      palette_index_pointer <= INDEX_RST;
      phase                 <= PHASE_RED;
      red_hold              <= BLACK_LEVEL;
      green_hold            <= BLACK_LEVEL;
      rd_entry              <= ENTRY_RST;
      rd_tlo                <= 1'b0;
      rd_thi                <= 1'b0;
      wr_act_q              <= 1'b0;
      rd_act_q              <= 1'b0;
      dq_out                <= BUS_IDLE;
      dq_oe                 <= 1'b0;
    end else if (ce_i) begin
      palette_index_pointer <= next_palette_index_pointer;
      phase                 <= next_phase;
      red_hold              <= next_red_hold;
      green_hold            <= next_green_hold;
      rd_entry              <= next_rd_entry;
      rd_tlo                <= next_rd_tlo;
      rd_thi                <= next_rd_thi;
      wr_act_q              <= wr_act;
      rd_act_q              <= rd_act;
      dq_out                <= next_dq_out;
      dq_oe                 <= next_dq_oe;
    end
  end

  assign bus.dev_dq_out = dq_out;
  assign bus.dev_dq_oe  = dq_oe;

  // Storage writes, only at the close of a blue byte
  always_ff @(posedge clk_i) begin
    if (ce_i && !sys_rst_i) begin
      if (pal_we) begin
        palette_mem[mem_addr] <= mem_wdata;
      end
      if (ovl_we) begin
        overlay_mem[mem_addr[1:0]] <= mem_wdata;
      end
    end
  end

  // Pixel lookup path
  assign pick = {overlay_pick_hi_i, overlay_pick_lo_i};

  // Lookup in a process so that storage writes also refresh the entry
  always_comb begin
    pix_entry  = fetch_entry(pick != 2'h0,
                             (pick != 2'h0) ? {6'h00, pick} : pixel_index_in_i);
    next_red   = pix_entry[23:16];
    next_green = pix_entry[15:8];
    next_blue  = pix_entry[7:0];
    // RULE2: pixel inputs ignored
    // RULE8: black while select low
    if (!cs_n_s) begin
      next_red   = BLACK_LEVEL;
      next_green = BLACK_LEVEL;
      next_blue  = BLACK_LEVEL;
    end
  end

  // Color output registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      red_o   <= BLACK_LEVEL;
      green_o <= BLACK_LEVEL;
      blue_o  <= BLACK_LEVEL;
    end else if (ce_i) begin
      red_o   <= next_red;
      green_o <= next_green;
      blue_o  <= next_blue;
    end
  end

endmodule

// [palette_host_end.sv]
// Host controller end: turns Avalon-MM commands into single pin cycles
// on the palette host port, one byte per command.
// Assumes an Avalon master that holds each request until waitrequest is low.
`timescale 1ns/1ps
module palette_host_end #(
  parameter logic [3:0] SETUP_CYC_P  = palette_port_pkg::SETUP_CYC,
  parameter logic [3:0] STROBE_CYC_P = palette_port_pkg::STROBE_CYC,
  parameter logic [3:0] HOLD_CYC_P   = palette_port_pkg::HOLD_CYC,
  parameter logic [3:0] GAP_CYC_P    = palette_port_pkg::GAP_CYC
) (
  input  wire logic                                   clk_i,
  input  wire logic                                   sys_rst_i,
  input  wire logic                                   ce_i,
  input  wire logic [palette_port_pkg::AV_ADDR_W-1:0] avs_address_i,
  input  wire logic                                   avs_read_i,
  input  wire logic                                   avs_write_i,
  input  wire logic [palette_port_pkg::AV_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]                             avs_byteenable_i,
  output logic      [palette_port_pkg::AV_DATA_W-1:0] avs_readdata_o,
  output logic                                        avs_waitrequest_o,
  palette_host_if.host                                bus
);
  import palette_port_pkg::*;

  host_state_t state;
  host_state_t next_state;
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic        is_read;
  logic        next_is_read;
  logic [7:0]  result;
  logic [7:0]  next_result;
  logic [31:0] next_readdata;
  logic        next_waitrequest;
  logic        cs_n;
  logic        next_cs_n;
  logic        rd_n;
  logic        next_rd_n;
  logic        wr_n;
  logic        next_wr_n;
  logic        tlo;
  logic        next_tlo;
  logic        thi;
  logic        next_thi;
  logic [7:0]  dq;
  logic [7:0]  next_dq;
  logic        dq_oe;
  logic        next_dq_oe;
  logic [7:0]  rx1;
  logic [7:0]  rx2;

  // Two-stage crossing of the device's read data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rx1 <= BUS_IDLE;
      rx2 <= BUS_IDLE;
    end else if (ce_i) begin
      rx1 <= bus.host_data_bus;
      rx2 <= rx1;
    end
  end

  // Command decode and pin cycle sequencing
  always_comb begin
    next_state       = state;
    next_cnt         = cnt;
    next_is_read     = is_read;
    next_result      = result;
    next_readdata    = avs_readdata_o;
    next_waitrequest = 1'b1;
    next_cs_n        = cs_n;
    next_rd_n        = rd_n;
    next_wr_n        = wr_n;
    next_tlo         = tlo;
    next_thi         = thi;
    next_dq          = dq;
    next_dq_oe       = dq_oe;
    unique case (state)
      ST_IDLE: begin
        if (avs_read_i) begin
          next_readdata    = (avs_address_i == OFS_RESULT) ? {24'h000000, result} : 32'h0;
          next_waitrequest = 1'b0;
          next_state       = ST_ACK;
        end else if (avs_write_i && avs_address_i == OFS_CMD &&
                     avs_byteenable_i[1:0] == 2'b11) begin
          // RULE1: select low for the whole cycle
          next_cs_n    = 1'b0;
          // RULE3: target pins from command
          next_tlo     = avs_writedata_i[CMD_TLO_BIT];
          next_thi     = avs_writedata_i[CMD_THI_BIT];
          next_is_read = avs_writedata_i[CMD_READ_BIT];
          next_dq      = avs_writedata_i[7:0];
          next_dq_oe   = !avs_writedata_i[CMD_READ_BIT];
          next_cnt     = SETUP_CYC_P;
          next_state   = ST_SETUP;
        end else if (avs_write_i) begin
          next_waitrequest = 1'b0;
          next_state       = ST_ACK;
        end
      end
      ST_ACK: begin
        next_state = ST_IDLE;
      end
      ST_SETUP: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          // RULE17: only one strobe at a time
          next_rd_n  = !is_read;
          next_wr_n  = is_read;
          next_cnt   = STROBE_CYC_P;
          next_state = ST_STROBE;
        end
      end
      ST_STROBE: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          // RULE7: byte taken at strobe end
          if (is_read) begin
            next_result = rx2;
          end
          next_rd_n  = 1'b1;
          next_wr_n  = 1'b1;
          next_cnt   = HOLD_CYC_P;
          next_state = ST_HOLD;
        end
      end
      ST_HOLD: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_cs_n  = 1'b1;
          next_dq_oe = 1'b0;
          next_cnt   = GAP_CYC_P;
          next_state = ST_GAP;
        end
      end
      ST_GAP: begin
        next_cnt = cnt - 4'h1;
        if (cnt == 4'h1) begin
          next_waitrequest = 1'b0;
          next_state       = ST_ACK;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Sequencer and pin registers
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state             <= ST_IDLE;
      cnt               <= 4'h0;
      is_read           <= 1'b0;
      result            <= 8'h00;
      avs_readdata_o    <= 32'h0;
      avs_waitrequest_o <= 1'b1;
      cs_n              <= 1'b1;
      rd_n              <= 1'b1;
      wr_n              <= 1'b1;
      tlo               <= 1'b0;
      thi               <= 1'b0;
      dq                <= BUS_IDLE;
      dq_oe             <= 1'b0;
    end else if (ce_i) begin
      state             <= next_state;
      cnt               <= next_cnt;
      is_read           <= next_is_read;
      result            <= next_result;
      avs_readdata_o    <= next_readdata;
      avs_waitrequest_o <= next_waitrequest;
      cs_n              <= next_cs_n;
      rd_n              <= next_rd_n;
      wr_n              <= next_wr_n;
      tlo               <= next_tlo;
      thi               <= next_thi;
      dq                <= next_dq;
      dq_oe             <= next_dq_oe;
    end
  end

  assign bus.cs_n            = cs_n;
  assign bus.rd_n            = rd_n;
  assign bus.wr_n            = wr_n;
  assign bus.target_sel_low  = tlo;
  assign bus.target_sel_high = thi;
  assign bus.host_dq_out     = dq;
  assign bus.host_dq_oe      = dq_oe;

endmodule

// [palette_host_checker.sv]
// Pin-level checks on the link between the palette host and device ends.
// Assumes it is instantiated beside the interface and sees its signals.
`timescale 1ns/1ps
module palette_host_checker (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       target_sel_low,
  input wire logic       target_sel_high,
  input wire logic [7:0] host_dq_out,
  input wire logic       host_dq_oe,
  input wire logic       dev_dq_oe
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // Write strobe width, then data held past its rise
  sequence wr_pulse_s;
    !wr_n [*8] ##1 wr_n;
  endsequence
  sequence wr_hold_s;
    (!cs_n && host_dq_oe && $stable(host_dq_out)) [*3];
  endsequence

  a_no_triple_low: assert property (cs_n || rd_n || wr_n)
    else $error("select and both strobes low together");
  a_strobe_in_sel: assert property ((!rd_n || !wr_n) |-> !cs_n)
    else $error("strobe active without select");
  a_wr_pulse_len: assert property ($fell(wr_n) |-> wr_pulse_s)
    else $error("write strobe width wrong");
  a_wr_data_hold: assert property ($rose(wr_n) |-> wr_hold_s)
    else $error("write data or select not held after strobe");
  a_rd_answer_time: assert property ($fell(rd_n) |-> ##[2:4] dev_dq_oe)
    else $error("device did not drive read data");
  a_dev_release: assert property ($rose(cs_n) |-> ##[0:4] !dev_dq_oe)
    else $error("device kept driving after select rise");
  a_no_bus_fight: assert property (!rd_n |-> !host_dq_oe)
    else $error("host drives bus during read");
  a_target_stable: assert property (!cs_n && !$past(cs_n) |->
    $stable({target_sel_low, target_sel_high}))
    else $error("command pins moved during access");
endmodule

// [tb_top.sv]
// Testbench: Avalon commands into the host end, pixel lookups on the device end.
// Assumes the default pin timing parameters of the host end.
`timescale 1ns/1ps
module tb_top;
  import palette_port_pkg::*;
  logic        clk_i     = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic [3:0]  av_addr   = 4'h0;
  logic        av_rd     = 1'b0;
  logic        av_wr     = 1'b0;
  logic [31:0] av_wdata  = 32'h0;
  logic [31:0] av_rdata;
  logic        av_wait;
  logic [7:0]  pix_idx   = 8'h00;
  logic        pick_lo   = 1'b0;
  logic        pick_hi   = 1'b0;
  logic [7:0]  red, green, blue, rb;
  int          err_count   = 0;
  int          check_count = 0;
  int          cycles      = 0;

  palette_host_if bus ();
  palette_host_end palette_host_end_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .avs_address_i(av_addr), .avs_read_i(av_rd), .avs_write_i(av_wr),
    .avs_writedata_i(av_wdata), .avs_byteenable_i(4'hF), .avs_readdata_o(av_rdata),
    .avs_waitrequest_o(av_wait), .bus(bus));
  palette_device_end palette_device_end_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .ce_i(1'b1), .bus(bus), .pixel_index_in_i(pix_idx), .overlay_pick_lo_i(pick_lo),
    .overlay_pick_hi_i(pick_hi), .red_o(red), .green_o(green), .blue_o(blue));
  palette_host_checker palette_host_checker_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .cs_n(bus.cs_n), .rd_n(bus.rd_n), .wr_n(bus.wr_n), .target_sel_low(bus.target_sel_low),
    .target_sel_high(bus.target_sel_high), .host_dq_out(bus.host_dq_out),
    .host_dq_oe(bus.host_dq_oe), .dev_dq_oe(bus.dev_dq_oe));

  always #2.5 clk_i = ~clk_i;

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Hang guard, well above the length of the sequence
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      err_count++;
      $display("CHECK FAILED at %0t: timeout", $time);
      tally_and_finish();
    end
  end

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One Avalon transfer, held until waitrequest is seen low
  task automatic av(input logic [3:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_i);
    av_addr <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_wdata <= d;
    do @(posedge clk_i); while (av_wait !== 1'b0);
    rb = av_rdata[7:0];
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask

  task automatic pw(input logic lo, input logic hi, input logic [7:0] d);
    av(OFS_CMD, 1'b1, {21'h0, 1'b0, hi, lo, d});
  endtask
  task automatic pr(input logic lo, input logic hi, input logic [7:0] exp);
    av(OFS_CMD, 1'b1, {21'h0, 1'b1, hi, lo, 8'h00});
    av(OFS_RESULT, 1'b0, 32'h0);
    chk8(rb, exp);
  endtask
  task automatic wr3(input logic hi, input logic [7:0] r, g, b);
    pw(1'b1, hi, r);
    pw(1'b1, hi, g);
    pw(1'b1, hi, b);
  endtask
  task automatic rd3(input logic hi, input logic [7:0] r, g, b);
    pr(1'b1, hi, r);
    pr(1'b1, hi, g);
    pr(1'b1, hi, b);
  endtask
  task automatic pix(input logic lo, hi, input logic [7:0] i, r, g, b);
    @(posedge clk_i);
    pick_lo <= lo;
    pick_hi <= hi;
    pix_idx <= i;
    repeat (3) @(negedge clk_i);
    chk8(red, r);
    chk8(green, g);
    chk8(blue, b);
  endtask

  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    pr(1'b0, 1'b0, INDEX_RST);
    av(4'h8, 1'b0, 32'h0);
    chk8(rb, 8'h00);
    // tables loaded before any pixel lookup is checked
    pw(1'b0, 1'b0, 8'hFE);
    wr3(1'b0, 8'h11, 8'h22, 8'h33);
    wr3(1'b0, 8'h44, 8'h55, 8'h66);
    pr(1'b0, 1'b0, 8'h00);
    pw(1'b0, 1'b0, 8'hFE);
    rd3(1'b0, 8'h11, 8'h22, 8'h33);
    rd3(1'b0, 8'h44, 8'h55, 8'h66);
    pr(1'b0, 1'b0, 8'h00);
    pw(1'b0, 1'b0, 8'h10);
    pw(1'b1, 1'b0, 8'hAA);
    pw(1'b0, 1'b0, 8'h10);
    wr3(1'b0, 8'h01, 8'h02, 8'h03);
    pw(1'b0, 1'b0, 8'h10);
    rd3(1'b0, 8'h01, 8'h02, 8'h03);
    pw(1'b0, 1'b0, 8'h20);
    pw(1'b1, 1'b0, 8'h0A);
    pr(1'b0, 1'b0, 8'h20);
    pw(1'b1, 1'b0, 8'h0B);
    pw(1'b1, 1'b0, 8'h0C);
    pr(1'b0, 1'b0, 8'h21);
    pw(1'b0, 1'b0, 8'h20);
    rd3(1'b0, 8'h0A, 8'h0B, 8'h0C);
    pw(1'b0, 1'b0, 8'hF5);
    wr3(1'b1, 8'h77, 8'h88, 8'h99);
    pr(1'b0, 1'b0, 8'hF6);
    pw(1'b0, 1'b1, 8'h04);
    wr3(1'b1, 8'hC1, 8'hC2, 8'hC3);
    pr(1'b0, 1'b0, 8'h05);
    pw(1'b0, 1'b0, 8'h04);
    rd3(1'b1, 8'h00, 8'h00, 8'h00);
    pix(1'b1, 1'b0, 8'h00, 8'h77, 8'h88, 8'h99);
    pix(1'b0, 1'b0, 8'hFF, 8'h44, 8'h55, 8'h66);
    // Colors during an access, with the pixel input moved meanwhile
    fork
      pr(1'b0, 1'b0, 8'h05);
      begin
        wait (bus.cs_n === 1'b0);
        @(posedge clk_i);
        pix_idx <= 8'hFE;
        repeat (5) @(negedge clk_i);
        chk8(red, BLACK_LEVEL);
        chk8(blue, BLACK_LEVEL);
      end
    join
    pix(1'b0, 1'b0, 8'hFE, 8'h11, 8'h22, 8'h33);
    tally_and_finish();
  end
endmodule
